// ===== verilog/cssl_pkg_sync.sv
// package of shared constants and types, plus the two-stage level synchroniser
// assumes a single system clock; power good enters through cssl_sync for the sequencer but also drives the async clear and buffer directly
`timescale 1ns/100ps
`default_nettype none

package cssl_pkg;
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    // software-requested bus reset width, in nanoseconds
    localparam int unsigned SWRST_HOLD_NS  = 1000;
    localparam int unsigned SWRST_CYCLES   = (SWRST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    // clock-select reset trails bus reset by this many clocks
    localparam int unsigned CSEL_TRAIL     = 2;
    localparam int unsigned NUM_FLAGS      = 8;
    localparam logic [1:0]  ERR_NONE       = 2'h0;
    localparam logic [1:0]  ERR_INTERNAL   = 2'h1;
    localparam logic [1:0]  ERR_MEM_MULTI  = 2'h2;
    localparam logic [1:0]  ERR_SYS_BUS    = 2'h3;
    localparam logic [1:0]  SYNC_RESET_VAL = 2'h0;

    typedef enum logic [1:0] {
        CSSL_PWR  = 2'h0,
        CSSL_CSEL = 2'h1,
        CSSL_RUN  = 2'h3,
        CSSL_SWR  = 2'h2
    } cssl_state_e;

    // one-cycle error event pulses from the detecting units
    typedef struct packed {
        logic xbus_parity;
        logic mem_multi_ecc;
        logic addr_parity;
        logic req_parity;
        logic protocol_viol;
        logic bus_error;
        logic host_multi_ecc;
    } cssl_err_s;
endpackage

module cssl_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic d,
    output logic      q
);
    logic [1:0] stage;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= cssl_pkg::SYNC_RESET_VAL;
        end else begin
            stage <= {stage[0], d};
        end
    end

    assign q = stage[1];
endmodule // cssl_sync

`default_nettype wire

// ===== verilog/cssl_top.sv
// controller support signals: bus reset, clock-select reset, error code,
// interrupt request, buffered power good, management mode indicator
// assumes event and control inputs come from logic on CLK_SYS; power good is a pin
`timescale 1ns/100ps
`default_nettype none

module cssl_top #(
    parameter int unsigned NUM_FLAGS    = cssl_pkg::NUM_FLAGS,
    parameter int unsigned SWRST_CYCLES = cssl_pkg::SWRST_CYCLES
) (
    // clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST_N,
    // power good pin and its buffered copy
    input  wire logic                  POWER_GOOD_IN,
    output logic                       BUFFERED_POWER_GOOD_OUT,
    // system bus reset, two-way pin
    input  wire logic                  SYS_BUS_RESET_N_IN,
    output logic                       SYS_BUS_RESET_N_OUT,
    output logic                       SYS_BUS_RESET_OE,
    // clock-select reset
    output logic                       CLOCK_SELECT_RESET_OUT_N,
    // software reset request, one-cycle pulse
    input  wire logic                  SW_RESET_REQ,
    // error events and open-drain error code
    input  wire cssl_pkg::cssl_err_s   ERR_EVENT,
    input  wire logic                  ERR_CLEAR,
    output logic [1:0]                 ERR_CODE_N_OUT,
    output logic [1:0]                 ERR_CODE_OE,
    // status flags and interrupt request
    input  wire logic [NUM_FLAGS-1:0]  STATUS_SET,
    input  wire logic [NUM_FLAGS-1:0]  STATUS_CLEAR,
    input  wire logic [NUM_FLAGS-1:0]  STATUS_INT_EN,
    output logic [NUM_FLAGS-1:0]       STATUS_FLAGS,
    output logic                       INTERRUPT_REQUEST_OUT_N,
    // system management mode
    input  wire logic                  SMM_ACTIVE_IN,
    output logic                       SYS_MGMT_MODE_ACTIVE_N
);
    localparam int unsigned CW = $clog2(SWRST_CYCLES + 1);

    // power good low clears the block, all but the cssl_sync stages, without a clock edge
    wire logic arst_n = RST_N & POWER_GOOD_IN;
    wire logic pg_sync;

    cssl_sync cssl_sync_inst (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (POWER_GOOD_IN),
        .q     (pg_sync)
    );

    // pass-through, no resynchronisation so the bridges see power good at once
    assign BUFFERED_POWER_GOOD_OUT = POWER_GOOD_IN;

    // reset sequencer
    cssl_pkg::cssl_state_e state;
    cssl_pkg::cssl_state_e next_state;
    logic [CW-1:0]         cnt;
    logic [CW-1:0]         next_cnt;
    logic                  sys_rst;
    logic                  csel_rst;

    wire logic cnt_done  = (cnt == CW'(SWRST_CYCLES - 1));
    wire logic csel_done = (cnt == CW'(cssl_pkg::CSEL_TRAIL - 1));

    always_comb begin
        next_state = state;
        next_cnt   = '0;
        unique case (state)
            cssl_pkg::CSSL_PWR: begin
                if (pg_sync) begin
                    next_state = cssl_pkg::CSSL_CSEL;
                end
            end
            cssl_pkg::CSSL_CSEL: begin
                if (csel_done) begin
                    next_state = cssl_pkg::CSSL_RUN;
                end else begin
                    next_cnt = cnt + CW'(1);
                end
            end
            cssl_pkg::CSSL_RUN: begin
                if (SW_RESET_REQ) begin
                    next_state = cssl_pkg::CSSL_SWR;
                end
            end
            cssl_pkg::CSSL_SWR: begin
                if (cnt_done) begin
                    next_state = cssl_pkg::CSSL_CSEL;
                end else begin
                    next_cnt = cnt + CW'(1);
                end
            end
        endcase
    end

    wire logic next_sys_rst  = (next_state == cssl_pkg::CSSL_PWR)
                             | (next_state == cssl_pkg::CSSL_SWR);
    // same edge as bus reset, or the async clear, so both rise together
    wire logic next_csel_rst = (next_state != cssl_pkg::CSSL_RUN);

    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            state    <= cssl_pkg::CSSL_PWR;
            cnt      <= '0;
            sys_rst  <= 1'b1;
            csel_rst <= 1'b1;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            sys_rst  <= next_sys_rst;
            csel_rst <= next_csel_rst;
        end
    end

    // reset pin is always driven; its input side is only used by board test
    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            SYS_BUS_RESET_N_OUT      <= 1'b0;
            SYS_BUS_RESET_OE         <= 1'b1;
            CLOCK_SELECT_RESET_OUT_N <= 1'b0;
        end else begin
            SYS_BUS_RESET_N_OUT      <= ~next_sys_rst;
            SYS_BUS_RESET_OE         <= 1'b1;
            CLOCK_SELECT_RESET_OUT_N <= ~next_csel_rst;
        end
    end

    // error latching: sticky until cleared, a new event beats the clear
    wire logic ev_int = ERR_EVENT.xbus_parity;
    wire logic ev_mem = ERR_EVENT.mem_multi_ecc;
    wire logic ev_sys = ERR_EVENT.addr_parity | ERR_EVENT.req_parity
                      | ERR_EVENT.protocol_viol | ERR_EVENT.bus_error
                      | ERR_EVENT.host_multi_ecc;
    logic [2:0] err_flag;
    wire logic [2:0] next_err_flag = {ev_sys, ev_mem, ev_int} | (ERR_CLEAR ? 3'h0 : err_flag);
    // most severe source wins when several are pending
    wire logic [1:0] next_code = next_err_flag[2] ? cssl_pkg::ERR_SYS_BUS   :
                                 next_err_flag[1] ? cssl_pkg::ERR_MEM_MULTI :
                                 next_err_flag[0] ? cssl_pkg::ERR_INTERNAL  :
                                                    cssl_pkg::ERR_NONE;
    logic [1:0] err_code;

    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            err_flag       <= 3'h0;
            err_code       <= cssl_pkg::ERR_NONE;
            ERR_CODE_N_OUT <= 2'h0;
            ERR_CODE_OE    <= 2'h0;
        end else begin
            err_flag       <= next_err_flag;
            err_code       <= next_code;
            ERR_CODE_N_OUT <= 2'h0;
            // open drain: pull low only where the code bit is one
            ERR_CODE_OE    <= next_code;
        end
    end

    // status flags, set wins over clear
    wire logic [NUM_FLAGS-1:0] next_flags;

    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        assign next_flags[i] = STATUS_SET[i] | (STATUS_FLAGS[i] & ~STATUS_CLEAR[i]);
    end

    wire logic next_irq = |(next_flags & STATUS_INT_EN);

    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            STATUS_FLAGS            <= '0;
            INTERRUPT_REQUEST_OUT_N <= 1'b1;
            SYS_MGMT_MODE_ACTIVE_N  <= 1'b1;
        end else begin
            STATUS_FLAGS            <= next_flags;
            INTERRUPT_REQUEST_OUT_N <= ~next_irq;
            SYS_MGMT_MODE_ACTIVE_N  <= ~SMM_ACTIVE_IN;
        end
    end

    // check helper: clocks of software bus reset seen so far, cleared otherwise
    logic [CW-1:0] rst_len;

    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            rst_len <= '0;
        end else if (sys_rst && (state == cssl_pkg::CSSL_SWR)) begin
            rst_len <= rst_len + CW'(1);
        end else begin
            rst_len <= '0;
        end
    end

    // checks
    csel_with_rst_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        sys_rst |-> csel_rst && !CLOCK_SELECT_RESET_OUT_N)
        else $error("clock-select reset low while bus reset high");

    csel_trail_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        $fell(sys_rst) |-> csel_rst ##1 csel_rst ##1 !csel_rst)
        else $error("clock-select reset did not trail by two clocks");

    err_none_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (err_flag == 3'h0) |-> (err_code == 2'h0) && (ERR_CODE_OE == 2'h0))
        else $error("error code shown with no error pending");

    err_internal_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (ev_int && !ev_mem && !ev_sys && err_flag[2:1] == 2'h0) |=> (ERR_CODE_OE == 2'h1))
        else $error("internal error not coded 01");

    err_mem_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (ev_mem && !ev_sys && !err_flag[2]) |=> (ERR_CODE_OE == 2'h2))
        else $error("memory error not coded 10");

    err_sysbus_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        ev_sys |=> (ERR_CODE_OE == 2'h3) && (err_code == 2'h3))
        else $error("system bus error not coded 11");

    irq_on_flag_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        |(STATUS_SET & STATUS_INT_EN) |=> !INTERRUPT_REQUEST_OUT_N && |STATUS_FLAGS)
        else $error("enabled flag set without interrupt");

    pg_buffer_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        BUFFERED_POWER_GOOD_OUT == POWER_GOOD_IN)
        else $error("buffered power good differs from input");

    rst_driven_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        SYS_BUS_RESET_OE && (SYS_BUS_RESET_N_OUT == !sys_rst))
        else $error("bus reset pin not driven");

    sw_reset_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (state == cssl_pkg::CSSL_RUN && SW_RESET_REQ) |=> sys_rst && !SYS_BUS_RESET_N_OUT)
        else $error("software request did not reset the bus");

    sw_width_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        ($fell(sys_rst) && ($past(state) == cssl_pkg::CSSL_SWR))
        |-> (rst_len == CW'(SWRST_CYCLES)))
        else $error("software bus reset width wrong");

    sw_bound_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        rst_len <= CW'(SWRST_CYCLES))
        else $error("software bus reset held too long");

    smm_shown_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        SMM_ACTIVE_IN |=> !SYS_MGMT_MODE_ACTIVE_N)
        else $error("management mode not shown");

    pg_hold_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        !pg_sync |-> sys_rst && csel_rst)
        else $error("reset released before power good");

    // the input side of the pin must follow what is driven onto it
    rst_loop_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        SYS_BUS_RESET_OE |-> (SYS_BUS_RESET_N_IN == SYS_BUS_RESET_N_OUT))
        else $error("bus reset wire differs from driven level");

    csel_rise_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        $rose(csel_rst) |-> sys_rst)
        else $error("clock-select reset rose without bus reset");

    csel_trail_st_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (state == cssl_pkg::CSSL_CSEL) |-> csel_rst && !sys_rst)
        else $error("trailing phase shows wrong reset levels");

    run_free_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (state == cssl_pkg::CSSL_RUN) |-> !csel_rst && !sys_rst)
        else $error("reset still asserted while running");

    err_clear_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (ERR_CLEAR && (ERR_EVENT == '0)) |=> (ERR_CODE_OE == cssl_pkg::ERR_NONE))
        else $error("error code not cleared");

    err_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (!ERR_CLEAR && (ERR_EVENT == '0)) |=> $stable(ERR_CODE_OE))
        else $error("error code changed with no event");

    err_drain_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        ERR_CODE_N_OUT == 2'h0)
        else $error("error code data not low");

    flag_set_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        (STATUS_SET != '0) |=> (($past(STATUS_SET) & ~STATUS_FLAGS) == '0))
        else $error("status flag set lost");

    irq_match_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        INTERRUPT_REQUEST_OUT_N == !(|(STATUS_FLAGS & $past(STATUS_INT_EN))))
        else $error("interrupt request differs from enabled flags");

    smm_gone_a: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        !SMM_ACTIVE_IN |=> SYS_MGMT_MODE_ACTIVE_N)
        else $error("management mode shown while inactive");
endmodule // cssl_top

`default_nettype wire

// ===== tb/cssl_bus_agent.sv
// far-side bus agents: pulled-up reset wire and open-drain error code wires
// assumes the device drives active-low levels beside high-true enables
`timescale 1ns/100ps
`default_nettype none

module cssl_bus_agent (
    // device side
    input  wire logic       rst_n_out,
    input  wire logic       rst_oe,
    input  wire logic [1:0] err_n_out,
    input  wire logic [1:0] err_oe,
    // resolved wire levels
    output logic            rst_wire_n,
    output logic [1:0]      err_wire_n
);
    // a released wire floats up to the pull-up, never to the last value
    assign rst_wire_n = rst_oe ? rst_n_out : 1'b1;
    assign err_wire_n = (err_oe & err_n_out) | ~err_oe;
endmodule // cssl_bus_agent

`default_nettype wire

// ===== tb/cssl_top_test.sv
// self-checking bench for the controller support signal block
// assumes cssl_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none

module cssl_top_test;
    localparam int unsigned SWR = 4;
    logic                clk_sys = 1'b0;
    logic                rst_n   = 1'b0;
    logic                pg      = 1'b0;
    logic                sw_req  = 1'b0;
    logic                err_clr = 1'b0;
    logic                smm     = 1'b0;
    logic [7:0]          st_set  = 8'h00;
    logic [7:0]          st_clr  = 8'h00;
    logic [7:0]          st_en   = 8'h00;
    cssl_pkg::cssl_err_s err_ev  = '0;
    logic                bpg, rst_n_out, rst_oe, rst_wire_n, csel_n, irq_n, smm_n;
    logic [1:0]          err_n_out, err_oe, err_wire_n;
    logic [7:0]          flags;
    int                  error_cnt, comparisons, cycles;

    always #2 clk_sys = ~clk_sys;

    cssl_top #(.NUM_FLAGS(8), .SWRST_CYCLES(SWR)) cssl_top_inst (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .POWER_GOOD_IN(pg),
        .BUFFERED_POWER_GOOD_OUT(bpg), .SYS_BUS_RESET_N_IN(rst_wire_n),
        .SYS_BUS_RESET_N_OUT(rst_n_out), .SYS_BUS_RESET_OE(rst_oe),
        .CLOCK_SELECT_RESET_OUT_N(csel_n), .SW_RESET_REQ(sw_req),
        .ERR_EVENT(err_ev), .ERR_CLEAR(err_clr), .ERR_CODE_N_OUT(err_n_out),
        .ERR_CODE_OE(err_oe), .STATUS_SET(st_set), .STATUS_CLEAR(st_clr),
        .STATUS_INT_EN(st_en), .STATUS_FLAGS(flags),
        .INTERRUPT_REQUEST_OUT_N(irq_n), .SMM_ACTIVE_IN(smm),
        .SYS_MGMT_MODE_ACTIVE_N(smm_n));

    cssl_bus_agent cssl_bus_agent_inst (
        .rst_n_out(rst_n_out), .rst_oe(rst_oe), .err_n_out(err_n_out),
        .err_oe(err_oe), .rst_wire_n(rst_wire_n), .err_wire_n(err_wire_n));

    task automatic close_out;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_code(input string what, input logic [1:0] e, input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_cnt(input string what, input int e, input int g);
        comparisons++;
        if (g != e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // counts low cycles of bus reset, then the two trailing clock-select cycles
    task automatic release_walk(input int exp_low);
        int n;
        n = 0;
        while (rst_wire_n !== 1'b1 && n < 1000) begin
            chk_bit("bus reset enable", 1'b1, rst_oe);
            tick(1);
            n++;
        end
        chk_cnt("bus reset low cycles", exp_low, n);
        chk_bit("clock select trail 0", 1'b0, csel_n);
        tick(1);
        chk_bit("clock select trail 1", 1'b0, csel_n);
        tick(1);
        chk_bit("clock select released", 1'b1, csel_n);
    endtask

    task automatic t_powerup;
        chk_bit("bus reset in reset", 1'b0, rst_wire_n);
        chk_bit("clock select in reset", 1'b0, csel_n);
        rst_n = 1'b1;
        tick(4);
        chk_bit("bus reset without power", 1'b0, rst_wire_n);
        chk_bit("clock select without power", 1'b0, csel_n);
        pg = 1'b1;
        #1;
        chk_bit("buffered power good", 1'b1, bpg);
        release_walk(3);
    endtask

    task automatic t_swreset;
        sw_req = 1'b1;
        tick(1);
        sw_req = 1'b0;
        chk_bit("sw bus reset", 1'b0, rst_wire_n);
        chk_bit("sw clock select", 1'b0, csel_n);
        release_walk(SWR);
    endtask

    task automatic t_errors;
        logic [1:0] e;
        for (int i = 0; i < 7; i++) begin
            e = (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h3;
            err_ev = cssl_pkg::cssl_err_s'(7'h40 >> i);
            tick(1);
            err_ev = '0;
            tick(1);
            chk_code("error enables", e, err_oe);
            chk_code("error wires", ~e, err_wire_n);
            err_clr = 1'b1;
            tick(1);
            err_clr = 1'b0;
            chk_code("error cleared", 2'h0, err_wire_n ^ 2'h3);
        end
        err_ev = cssl_pkg::cssl_err_s'(7'h60);
        err_clr = 1'b1;
        tick(1);
        err_ev = '0;
        err_clr = 1'b0;
        chk_code("memory over internal", 2'h2, err_oe);
        err_ev = cssl_pkg::cssl_err_s'(7'h41);
        tick(1);
        err_ev = '0;
        chk_code("system bus over all", 2'h3, err_oe);
    endtask

    task automatic t_irq;
        st_en = 8'h01;
        st_set = 8'h03;
        tick(1);
        st_set = 8'h00;
        chk_bit("flag 1 set", 1'b1, flags[1]);
        chk_bit("irq enabled flag", 1'b0, irq_n);
        st_clr = 8'h01;
        tick(1);
        st_clr = 8'h00;
        chk_bit("irq masked flag", 1'b1, irq_n);
        st_en = 8'h02;
        tick(1);
        chk_bit("irq second flag", 1'b0, irq_n);
        // set and clear in one cycle: the set must win
        st_set = 8'h01;
        st_clr = 8'h01;
        tick(1);
        st_set = 8'h00;
        st_clr = 8'h00;
        chk_bit("set beats clear", 1'b1, flags[0]);
        chk_bit("irq still raised", 1'b0, irq_n);
    endtask

    task automatic t_smm;
        smm = 1'b1;
        tick(1);
        chk_bit("smm shown", 1'b0, smm_n);
        smm = 1'b0;
        tick(1);
        chk_bit("smm gone", 1'b1, smm_n);
    endtask

    task automatic t_pgloss;
        pg = 1'b0;
        #1;
        chk_bit("buffered power lost", 1'b0, bpg);
        chk_bit("bus reset on loss", 1'b0, rst_wire_n);
        chk_bit("clock select on loss", 1'b0, csel_n);
        chk_code("errors wiped", 2'h0, err_oe);
        tick(3);
        chk_bit("held while low", 1'b0, csel_n);
        pg = 1'b1;
        release_walk(3);
    endtask

    // hang guard, far above the roughly 80 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            close_out;
        end
    end

    initial begin
        tick(20);
        t_powerup;
        t_swreset;
        // back to back: the next request lands on the first edge after the release edge
        t_swreset;
        t_errors;
        t_irq;
        t_smm;
        t_pgloss;
        close_out;
    end
endmodule // cssl_top_test

`default_nettype wire
